/* File: design/spi_pin_pkg.sv */
// Purpose: shared constants and carriers for the spi pin port
// Assumes: four shared port e lines, serial function by default
// Notes:   no registers reached by software
package spi_pin_pkg;
  localparam int          WORD_W        = 8;
  localparam int          FIFO_DEPTH    = 16;
  localparam int          CLK_MHZ       = 40;
  localparam int          SCLK_HALF_NS  = 100;
  localparam int          SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0]  GP_SEL_RST    = 4'h0;
  localparam logic [3:0]  GP_DIR_RST    = 4'h0;
  localparam logic [3:0]  GP_OUT_RST    = 4'h0;
  localparam int          LINE_SCLK     = 0;
  localparam int          LINE_MOSI     = 1;
  localparam int          LINE_MISO     = 2;
  localparam int          LINE_SS       = 3;

  typedef struct packed {
    logic [3:0] gp_sel;
    logic [3:0] gp_dir;
    logic [3:0] gp_out;
  } pin_cfg_t;

  typedef struct packed {
    logic [3:0] in;
    logic [3:0] out;
    logic [3:0] oe;
  } pin_bus_t;
endpackage : spi_pin_pkg

/* File: design/spi_byte_fifo.sv */
// Purpose: small synchronous fifo for transmit words
// Assumes: single clock, synchronous active high reset
// Notes:   one slot is not wasted; count tracks fill
`timescale 1ns/1ps
module spi_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // fill side
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  // drain side
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic [WIDTH-1:0]      rd_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             wr_go, rd_go;

  always_comb begin
    wr_go    = wr_valid_in && (cnt_reg != (AW+1)'(DEPTH));
    rd_go    = rd_ready_in && (cnt_reg != '0);
    wp_next  = wr_go ? wp_reg + 1'b1 : wp_reg;
    rp_next  = rd_go ? rp_reg + 1'b1 : rp_reg;
    cnt_next = cnt_reg + (AW+1)'(wr_go) - (AW+1)'(rd_go);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
    if (wr_go) mem_reg[wp_reg] <= wr_data_in;
  end

  assign wr_ready_out = (cnt_reg != (AW+1)'(DEPTH));
  assign rd_valid_out = (cnt_reg != '0);
  assign rd_data_out  = mem_reg[rp_reg];
endmodule : spi_byte_fifo

/* File: design/spi_port_pin_interface.sv */
// Purpose: spi port pins with master and slave directions and gp reuse
// Assumes: pins arrive unsynchronised; mode 0 (capture rising, shift falling)
// Notes:   link clock is sampled by clk_in, so slave sclk must stay slow
// Contract
// RULE1: as master miso is an input, as slave the device drives miso.
// RULE2: an unselected slave releases miso to high impedance.
// RULE3: as master mosi is driven out, as slave mosi is sampled.
// RULE4: each mosi bit is set a half serial clock period before its capture edge.
// RULE5: as master the device drives sclk to clock its slaves.
// RULE6: as slave sclk is an input from the outside master that times transfers.
// RULE7: as master ss is watched to detect another master, not as a select.
// RULE8: as slave the device takes part only while ss is asserted low.
// RULE9: after reset all four shared lines carry the serial function.
// RULE10: each line may be moved to gp use with its own direction.
// RULE11: a line in gp use reads inactive to the serial logic and is not driven by it; sclk_fall still takes the raw s3_reg sclk bit.
`timescale 1ns/1ps
module spi_port_pin_interface #(
  parameter int WIDTH = spi_pin_pkg::WORD_W,
  parameter int DEPTH = spi_pin_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  // mode and pin configuration
  input  wire logic                  master_mode_in,
  input  wire spi_pin_pkg::pin_cfg_t pin_cfg_in,
  // transmit words
  input  wire logic                  tx_valid_in,
  output logic                       tx_ready_out,
  input  wire logic [WIDTH-1:0]      tx_data_in,
  // received words
  output logic                       rx_valid_out,
  output logic [WIDTH-1:0]           rx_data_out,
  // status
  output logic                       busy_out,
  output logic                       mode_fault_out,
  output logic [3:0]                 gp_in_out,
  // pins: in, out, enable per line
  input  wire logic [3:0]            pin_in,
  output logic [3:0]                 pin_out,
  output logic [3:0]                 pin_oe_out
);
  localparam int CW = $clog2(WIDTH + 1);
  localparam int HW = $clog2(spi_pin_pkg::SCLK_HALF_CYC + 1);
  localparam logic [HW-1:0] HALF = HW'(spi_pin_pkg::SCLK_HALF_CYC);

  typedef enum logic [1:0] {IDLE, LOW_HALF, HIGH_HALF} st_t;

  logic [3:0] s1_reg, s2_reg, s3_reg;
  logic [3:0] srv;
  logic       ss_n, sclk_rise, sclk_fall, selected;

  // two-stage sync, third stage only for edge finding
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_reg <= 4'hf;
      s2_reg <= 4'hf;
      s3_reg <= 4'hf;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  always_comb begin
    // gp lines read idle in srv, but a high gp sclk line still gives sclk_fall
    srv = s2_reg;                                              // [RULE11]
    if (pin_cfg_in.gp_sel[spi_pin_pkg::LINE_SS]) srv[spi_pin_pkg::LINE_SS] = 1'b1; // [RULE11]
    if (pin_cfg_in.gp_sel[spi_pin_pkg::LINE_SCLK]) srv[spi_pin_pkg::LINE_SCLK] = 1'b0; // [RULE11]
    if (pin_cfg_in.gp_sel[spi_pin_pkg::LINE_MOSI]) srv[spi_pin_pkg::LINE_MOSI] = 1'b0; // [RULE11]
    if (pin_cfg_in.gp_sel[spi_pin_pkg::LINE_MISO]) srv[spi_pin_pkg::LINE_MISO] = 1'b0; // [RULE11]
    ss_n      = srv[spi_pin_pkg::LINE_SS];
    selected  = !master_mode_in && !ss_n;                      // [RULE8]
    sclk_rise = srv[spi_pin_pkg::LINE_SCLK] && !s3_reg[spi_pin_pkg::LINE_SCLK]; // [RULE6]
    sclk_fall = !srv[spi_pin_pkg::LINE_SCLK] && s3_reg[spi_pin_pkg::LINE_SCLK]; // [RULE6]
  end

  // transmit buffer
  logic             fifo_valid, fifo_pop;
  logic [WIDTH-1:0] fifo_data;

  spi_byte_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .wr_valid_in  (tx_valid_in),
    .wr_ready_out (tx_ready_out),
    .wr_data_in   (tx_data_in),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (fifo_pop),
    .rd_data_out  (fifo_data)
  );

  // shift engine
  st_t              st_reg, st_next;
  logic [WIDTH-1:0] sh_reg, sh_next, rx_reg, rx_next;
  logic [CW-1:0]    bit_reg, bit_next;
  logic [HW-1:0]    div_reg, div_next;
  logic             sclk_reg, sclk_next, fault_reg, fault_next;
  logic             rxv_reg, rxv_next, act_reg, act_next, busy_reg, busy_next;
  logic             din;

  always_comb begin
    st_next    = st_reg;
    sh_next    = sh_reg;
    rx_next    = rx_reg;
    bit_next   = bit_reg;
    div_next   = div_reg;
    sclk_next  = sclk_reg;
    fault_next = fault_reg;
    rxv_next   = 1'b0;
    act_next   = act_reg;
    fifo_pop   = 1'b0;
    din        = master_mode_in ? srv[spi_pin_pkg::LINE_MISO]   // [RULE1]
                                : srv[spi_pin_pkg::LINE_MOSI];  // [RULE3]
    if (master_mode_in) begin
      act_next = 1'b0;
      case (st_reg)
        IDLE: begin
          sclk_next = 1'b0;
          // low ss from another master blocks a start
          if (!ss_n) begin
            fault_next = 1'b1;                                 // [RULE7]
          end else if (fifo_valid) begin
            // first bit put out a half period before the first rise
            sh_next   = fifo_data;                             // [RULE4]
            fifo_pop  = 1'b1;
            bit_next  = '0;
            div_next  = HALF;
            st_next   = LOW_HALF;
          end
        end
        LOW_HALF: begin
          if (div_reg > HW'(1)) begin
            div_next = div_reg - 1'b1;
          end else begin
            sclk_next = 1'b1;                                  // [RULE5]
            rx_next   = {rx_reg[WIDTH-2:0], din};              // [RULE1]
            div_next  = HALF;
            st_next   = HIGH_HALF;
          end
        end
        HIGH_HALF: begin
          if (div_reg > HW'(1)) begin
            div_next = div_reg - 1'b1;
          end else begin
            sclk_next = 1'b0;                                  // [RULE5]
            div_next  = HALF;
            if (bit_reg == CW'(WIDTH - 1)) begin
              rxv_next = 1'b1;
              st_next  = IDLE;
            end else begin
              bit_next = bit_reg + 1'b1;
              sh_next  = {sh_reg[WIDTH-2:0], 1'b0};            // [RULE4]
              st_next  = LOW_HALF;
            end
          end
        end
        default: st_next = IDLE;
      endcase
      if (!ss_n && st_reg != IDLE) begin
        fault_next = 1'b1;                                     // [RULE7]
        sclk_next  = 1'b0;
        st_next    = IDLE;
      end
    end else begin
      st_next   = IDLE;
      sclk_next = 1'b0;
      if (!selected) begin
        act_next = 1'b0;                                       // [RULE8]
        bit_next = '0;
      end else begin
        if (!act_reg) begin
          act_next = 1'b1;
          bit_next = '0;
          sh_next  = fifo_valid ? fifo_data : '0;
          fifo_pop = fifo_valid;
        end
        if (sclk_rise) begin
          rx_next = {rx_reg[WIDTH-2:0], din};                  // [RULE3]
          if (bit_reg == CW'(WIDTH - 1)) begin
            rxv_next = 1'b1;
            bit_next = '0;
          end else begin
            bit_next = bit_reg + 1'b1;
          end
        end
        if (sclk_fall && act_reg) begin
          if (bit_reg == '0) begin
            sh_next  = fifo_valid ? fifo_data : '0;
            fifo_pop = fifo_valid;
          end else begin
            sh_next = {sh_reg[WIDTH-2:0], 1'b0};
          end
        end
      end
    end
    busy_next = (st_next != IDLE) || act_next;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_reg    <= IDLE;
      sh_reg    <= '0;
      rx_reg    <= '0;
      bit_reg   <= '0;
      div_reg   <= '0;
      sclk_reg  <= 1'b0;
      fault_reg <= 1'b0;
      rxv_reg   <= 1'b0;
      act_reg   <= 1'b0;
      busy_reg  <= 1'b0;
    end else begin
      st_reg    <= st_next;
      sh_reg    <= sh_next;
      rx_reg    <= rx_next;
      bit_reg   <= bit_next;
      div_reg   <= div_next;
      sclk_reg  <= sclk_next;
      fault_reg <= fault_next;
      rxv_reg   <= rxv_next;
      act_reg   <= act_next;
      busy_reg  <= busy_next;
    end
  end

  // pin drivers, registered
  logic [3:0] po_reg, po_next, oe_reg, oe_next, gpi_reg;

  always_comb begin
    po_next = 4'h0;
    oe_next = 4'h0;
    po_next[spi_pin_pkg::LINE_SCLK] = sclk_reg;
    oe_next[spi_pin_pkg::LINE_SCLK] = master_mode_in;          // [RULE5] [RULE6]
    po_next[spi_pin_pkg::LINE_MOSI] = sh_reg[WIDTH-1];
    oe_next[spi_pin_pkg::LINE_MOSI] = master_mode_in;          // [RULE3]
    po_next[spi_pin_pkg::LINE_MISO] = sh_reg[WIDTH-1];
    oe_next[spi_pin_pkg::LINE_MISO] = selected;                // [RULE1] [RULE2]
    for (int i = 0; i < 4; i++) begin
      if (pin_cfg_in.gp_sel[i]) begin
        po_next[i] = pin_cfg_in.gp_out[i];                     // [RULE10]
        oe_next[i] = pin_cfg_in.gp_dir[i];                     // [RULE10] [RULE11]
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      po_reg  <= 4'h0;
      oe_reg  <= 4'h0;                                         // [RULE9]
      gpi_reg <= 4'h0;
    end else begin
      po_reg  <= po_next;
      oe_reg  <= oe_next;
      gpi_reg <= s2_reg;
    end
  end

  assign pin_out        = po_reg;
  assign pin_oe_out     = oe_reg;
  assign gp_in_out      = gpi_reg;
  assign rx_valid_out   = rxv_reg;
  assign rx_data_out    = rx_reg;
  assign busy_out       = busy_reg;
  assign mode_fault_out = fault_reg;
endmodule : spi_port_pin_interface

/* File: verif/spi_port_pin_interface_sva.sv */
// Purpose: pin direction and timing checks for the spi pin port
// Assumes: tb holds pin_cfg_in at zero across every reset
// Notes:   sync depth of two plus a register gives the 4-cycle windows
`timescale 1ns/1ps
module spi_port_pin_interface_sva (
  input wire logic                  clk_in,
  input wire logic                  rst_in,
  input wire logic                  master_mode_in,
  input wire spi_pin_pkg::pin_cfg_t pin_cfg_in,
  input wire logic [3:0]            pin_in,
  input wire logic [3:0]            pin_out,
  input wire logic [3:0]            pin_oe_out,
  input wire logic                  busy_out,
  input wire logic                  mode_fault_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_master; master_mode_in && pin_cfg_in.gp_sel == 4'h0; endsequence
  sequence s_slave; !master_mode_in && pin_cfg_in.gp_sel == 4'h0; endsequence
  sequence s_unsel; !master_mode_in && pin_cfg_in.gp_sel == 4'h0 && pin_in[3]; endsequence
  property p_master_dirs; s_master ##1 s_master |-> pin_oe_out[2:0] == 3'h3; endproperty
  a_master_dirs: assert property (p_master_dirs) else $error("master directions");
  property p_slave_dirs; s_slave ##1 s_slave |-> pin_oe_out[1:0] == 2'h0; endproperty
  a_slave_dirs: assert property (p_slave_dirs) else $error("slave directions");
  property p_miso_release; s_unsel [*4] |-> !pin_oe_out[2]; endproperty
  a_miso_release: assert property (p_miso_release) else $error("miso not released");
  property p_unsel_idle; s_unsel [*4] |-> !busy_out; endproperty
  a_unsel_idle: assert property (p_unsel_idle) else $error("busy while unselected");
  property p_mosi_lead;
    master_mode_in && pin_oe_out[0] && $rose(pin_out[0]) |-> pin_out[1] == $past(pin_out[1], 3);
  endproperty
  a_mosi_lead: assert property (p_mosi_lead) else $error("mosi moved near capture");
  property p_fault_set; s_master and !pin_in[3] |-> ##[1:4] mode_fault_out; endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not raised");
  property p_fault_hold; mode_fault_out |=> mode_fault_out; endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault dropped");
  property p_reset_quiet;
    disable iff (1'b0) rst_in |=> pin_oe_out == 4'h0 && !busy_out && !mode_fault_out;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("pins active in reset");
  property p_gp_drive;
    $stable(pin_cfg_in) |-> (((pin_oe_out ^ pin_cfg_in.gp_dir) | ((pin_out ^ pin_cfg_in.gp_out)
      & pin_cfg_in.gp_dir)) & pin_cfg_in.gp_sel) == 4'h0;
  endproperty
  a_gp_drive: assert property (p_gp_drive) else $error("gp line drive wrong");
  property p_gp_ss; (!master_mode_in && pin_cfg_in.gp_sel[3]) [*4] |-> !busy_out; endproperty
  a_gp_ss: assert property (p_gp_ss) else $error("gp select line seen");
endmodule : spi_port_pin_interface_sva
bind spi_port_pin_interface spi_port_pin_interface_sva u_sva (.clk_in, .rst_in,
  .master_mode_in, .pin_cfg_in, .pin_in, .pin_out, .pin_oe_out, .busy_out, .mode_fault_out);

/* File: verif/spi_peer_model.sv */
// Purpose: far-side spi device, slave or master as the bench asks
// Assumes: mode 0, 200 ns serial clock when acting as master
// Notes:   clock stands low outside frames
`timescale 1ns/1ps
module spi_peer_model (
  input  wire logic [3:0] dut_out_in,
  input  wire logic [3:0] dut_oe_in,
  output logic [3:0]      drive_out,
  output logic [7:0]      got_out
);
  logic [7:0] sh_reg;
  logic [7:0] next_reg;
  int         bit_cnt;
  initial begin
    drive_out = 4'h8;
    got_out   = 8'h00;
    bit_cnt   = 0;
  end
  always @(posedge dut_out_in[0]) if (dut_oe_in[0]) got_out = {got_out[6:0], dut_out_in[1]};
  // miso moves on fall, a fresh byte after every eight
  always @(negedge dut_out_in[0]) if (dut_oe_in[0]) begin
    bit_cnt++;
    sh_reg = (bit_cnt % 8 == 0) ? next_reg : {sh_reg[6:0], 1'b0};
    drive_out[2] = sh_reg[7];
  end
  task load(input logic [7:0] first, input logic [7:0] second);
    sh_reg = first;
    next_reg = second;
    bit_cnt = 0;
    drive_out[2] = first[7];
  endtask : load
  task sel(input logic on);
    #7;
    drive_out[3] = !on;
    #400;
  endtask : sel
  task xfer(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      drive_out[1] = b[i];
      #100;
      drive_out[0] = 1'b1;
      r[i] = dut_out_in[2];
      #100;
      drive_out[0] = 1'b0;
    end
    drive_out[1] = ~b[0]; // no pull: released line shows the inverse
    #300;
  endtask : xfer
endmodule : spi_peer_model

/* File: verif/spi_port_pin_interface_tb.sv */
// Purpose: self-checking bench for the spi pin port
// Assumes: peer model stands on the far side of all four lines
// Notes:   fifo is filled to refusal, then drained in one select
`timescale 1ns/1ps
module spi_port_pin_interface_tb;
  logic                  clk_in, rst_in, master_mode_in, tx_valid_in, tx_ready_out;
  logic                  rx_valid_out, busy_out, mode_fault_out;
  spi_pin_pkg::pin_cfg_t pin_cfg_in;
  logic [7:0]            tx_data_in, rx_data_out, peer_got, got;
  logic [3:0]            gp_in_out, pin_in, pin_out, pin_oe_out, peer_drv;
  int                    mismatches, total_checks, n;
  spi_port_pin_interface uut (.clk_in, .rst_in, .master_mode_in, .pin_cfg_in, .tx_valid_in,
    .tx_ready_out, .tx_data_in, .rx_valid_out, .rx_data_out, .busy_out, .mode_fault_out,
    .gp_in_out, .pin_in, .pin_out, .pin_oe_out);
  spi_peer_model peer (.dut_out_in(pin_out), .dut_oe_in(pin_oe_out), .drive_out(peer_drv),
    .got_out(peer_got));
  assign pin_in = (pin_out & pin_oe_out) | (peer_drv & ~pin_oe_out);
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  task chk(input logic [7:0] act, input logic [7:0] exp);
    total_checks++;
    if (act !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, act, exp);
    end
  endtask : chk
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task cyc(input int c);
    repeat (c) @(negedge clk_in);
  endtask : cyc
  task wait_rx;
    int i;
    for (i = 0; i < 500; i++) begin
      cyc(1);
      if (rx_valid_out === 1'b1) break;
    end
    if (i == 500) begin
      chk(8'h00, 8'h01);
      close_out;
    end
  endtask : wait_rx
  task t_reset;
    rst_in = 1'b1;
    cyc(2);
    chk({4'h0, pin_oe_out}, 8'h00);
    chk({6'h0, busy_out, mode_fault_out}, 8'h00);
    rst_in = 1'b0;
    cyc(1);
    chk({7'h0, tx_ready_out}, 8'h01);
  endtask : t_reset
  task t_master;
    peer.load(8'h3c, 8'hc3);
    master_mode_in = 1'b1;
    cyc(2);
    chk({4'h0, pin_oe_out}, 8'h03);
    tx_valid_in = 1'b1;
    tx_data_in = 8'ha5;
    cyc(1);
    tx_data_in = 8'h5a;
    cyc(1);
    tx_valid_in = 1'b0;
    wait_rx;
    chk(rx_data_out, 8'h3c);
    chk(peer_got, 8'ha5);
    wait_rx;
    chk(rx_data_out, 8'hc3);
    chk(peer_got, 8'h5a);
  endtask : t_master
  task t_slave;
    master_mode_in = 1'b0;
    cyc(4);
    tx_valid_in = 1'b1;
    for (n = 0; n < 20 && tx_ready_out === 1'b1; n++) begin
      tx_data_in = {n[3:0], ~n[3:0]};
      cyc(1);
    end
    tx_valid_in = 1'b0;
    chk(8'(n), 8'h10);
    chk({7'h0, tx_ready_out}, 8'h00);
    peer.sel(1'b1);
    chk({6'h0, busy_out, pin_oe_out[2]}, 8'h03);
    for (int k = 0; k < 17; k++) begin
      peer.xfer(8'h96 ^ k[7:0], got);
      chk(got, (k < 16) ? {k[3:0], ~k[3:0]} : 8'h00);
      chk(rx_data_out, 8'h96 ^ k[7:0]);
    end
    peer.sel(1'b0);
    cyc(2);
    chk({6'h0, busy_out, pin_oe_out[2]}, 8'h00);
    chk({7'h0, tx_ready_out}, 8'h01);
  endtask : t_slave
  task t_fault;
    master_mode_in = 1'b1;
    cyc(2);
    peer.sel(1'b1);
    chk({7'h0, mode_fault_out}, 8'h01);
    peer.sel(1'b0);
    chk({7'h0, mode_fault_out}, 8'h01);
    cyc(1);
  endtask : t_fault
  task t_gp(input logic [3:0] outv);
    master_mode_in = 1'b0;
    pin_cfg_in = '{gp_sel: 4'hf, gp_dir: 4'h5, gp_out: outv};
    peer.sel(1'b1);
    chk({4'h0, pin_oe_out}, 8'h05);
    chk({4'h0, pin_out & 4'h5}, {4'h0, outv & 4'h5});
    chk({4'h0, gp_in_out}, {4'h0, peer_drv[3], outv[2], peer_drv[1], outv[0]});
    chk({7'h0, busy_out}, 8'h00);
    peer.sel(1'b0);
    pin_cfg_in = '0;
    cyc(2);
  endtask : t_gp
  initial begin
    rst_in = 1'b1;
    master_mode_in = 1'b0;
    pin_cfg_in = '0;
    tx_valid_in = 1'b0;
    tx_data_in = 8'h00;
    mismatches = 0;
    total_checks = 0;
    t_reset;
    t_master;
    t_slave;
    t_fault;
    t_reset;
    t_gp(4'h1);
    t_gp(4'h4);
    close_out;
  end
endmodule : spi_port_pin_interface_tb
